/* tdm_pkg.sv */
package tdm_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] TDM_OFF_CURRENT   = 8'h00;
   localparam logic [7:0] TDM_OFF_AVERAGE   = 8'h04;
   localparam logic [7:0] TDM_OFF_INTERVAL  = 8'h08;
   localparam logic [7:0] TDM_OFF_FLAGS     = 8'h0C;
   localparam logic [7:0] TDM_OFF_LIMIT     = 8'h10;
   localparam logic [7:0] TDM_OFF_CONTROL   = 8'h14;
   localparam logic [7:0] TDM_OFF_OVERRIDE  = 8'h18;
   // Reset values
   localparam logic [15:0] TDM_INTERVAL_RST = 16'h0100;
   localparam logic [7:0]  TDM_LIMIT_RST    = 8'hFF;
   // Band thresholds on the 8-bit result
   localparam logic [7:0] TDM_BAND_75   = 8'hC1;
   localparam logic [7:0] TDM_BAND_50   = 8'h81;
   localparam logic [7:0] TDM_BAND_25   = 8'h41;
   localparam logic [7:0] TDM_BAND_12   = 8'h21;
   // Flag bit positions in the band flag register
   localparam int TDM_FLG_FULL  = 0;
   localparam int TDM_FLG_B75   = 1;
   localparam int TDM_FLG_B50   = 2;
   localparam int TDM_FLG_B25   = 3;
   localparam int TDM_FLG_B12   = 4;
   localparam int TDM_FLG_B0    = 5;
   localparam int TDM_FLG_ANY   = 6;
   localparam int TDM_FLG_USER  = 7;
   // Control register bit positions
   localparam int TDM_CTL_HOT_DIS = 0;
   localparam int TDM_CTL_OVR_EN  = 1;
   // Hot response time and clock rate
   localparam int TDM_HOT_RESP_NS = 10000;
   localparam int TDM_CLK_NS      = 4;
   localparam int TDM_HOT_RESP_CY = TDM_HOT_RESP_NS / TDM_CLK_NS;
   // Sleep state codes
   typedef enum logic [1:0] {
      TDM_S0  = 2'b00,
      TDM_S3  = 2'b01,
      TDM_S45 = 2'b10
   } tdm_sleep_e;
   // AXI response codes
   localparam logic [1:0] TDM_RESP_OKAY   = 2'b00;
   localparam logic [1:0] TDM_RESP_SLVERR = 2'b10;
endpackage

/* tdm_throttle_duty_monitor.sv */
// What this block does
// - Measure asserted fraction as 8-bit 1/256 units
// - Interval register sets period; load current result
// - Average becomes (old average + previous current)/2
// - Host write to current restarts capture
// - Zero only if never asserted; else >=1
// - Code n means (n-1)/256 to n/256
// - Full flag when never released all interval
// - Band flags plus any-nonzero flag
// - Flag when result exceeds user limit
// - Sleep: stop, clear current, hold average
// - After wake, first result loads both unaveraged
// - Regulator hot drives throttle low within 10us
// - Hot drive off in sleep or by control
// - Override register drives PWM pattern on line
// - Band flags never feed the alert output
module tdm_throttle_duty_monitor
   import tdm_pkg::*;
#(
   parameter int HOT_INPUTS = 2
) (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // AXI4-Lite write address
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Throttle line, open drain, active low
   input  wire logic                  processor_throttle_line_i,
   output logic                       processor_throttle_line_oe,
   output logic                       processor_throttle_line_o,
   // Regulator hot inputs, active high after board inversion
   input  wire logic [HOT_INPUTS-1:0] regulator_hot_input,
   // Power state from system
   input  wire logic [1:0]            sleep_state,
   // Alert contribution, band flags excluded
   output logic                       alert_out
);

   // Refuse hot input counts the logic cannot serve
   if (HOT_INPUTS < 1 || HOT_INPUTS > 8) begin : g_bad_hot_inputs
      $error("HOT_INPUTS out of range");
   end

   // Input synchronisers
   logic [1:0]            thr_sync_q;  // Throttle line pin
   logic [HOT_INPUTS-1:0] hot_s1_q;    // Hot inputs stage 1
   logic [HOT_INPUTS-1:0] hot_s2_q;    // Hot inputs stage 2
   logic [1:0]            slp_s1_q;    // Sleep state stage 1
   logic [1:0]            slp_s2_q;    // Sleep state stage 2

   // Two flops before any logic reads a pin
   always_ff @(posedge aclk) begin
      thr_sync_q <= {thr_sync_q[0], processor_throttle_line_i};
      hot_s1_q   <= regulator_hot_input;
      hot_s2_q   <= hot_s1_q;
      slp_s1_q   <= sleep_state;
      slp_s2_q   <= slp_s1_q;
   end

   // Line is low while asserted
   wire throttle_asserted = ~thr_sync_q[1];
   wire asleep            = (slp_s2_q != TDM_S0);

   // Software registers
   logic [15:0] interval_q;  // Slot length in cycles, 256 slots per period
   logic [7:0]  limit_q;     // User limit
   logic [1:0]  control_q;   // Hot disable, override enable
   logic [15:0] override_q;  // High byte period minus one, low byte low time
   logic [7:0]  current_q;   // Current measurement
   logic [7:0]  average_q;   // Average measurement
   logic [7:0]  flags_q;     // Band flags

   // Measurement state
   logic [15:0] sub_q;       // Sub-slot divider inside one 1/256 slot
   logic [7:0]  slot_q;      // Slot index within the period
   logic [8:0]  hit_q;       // Slots touched by assertion
   logic        hit_slot_q;  // Assertion seen in this slot
   logic        released_q;  // Line seen released this period
   logic        first_q;     // Next result is first after wake

   // Bus handshake state
   logic        aw_got_q;
   logic        w_got_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;

   // Write decode
   wire do_write     = aw_got_q & w_got_q & ~s_axi_bvalid;
   wire wr_current   = do_write & (awaddr_q == TDM_OFF_CURRENT) & wstrb_q[0];
   wire wr_interval  = do_write & (awaddr_q == TDM_OFF_INTERVAL);
   wire wr_limit     = do_write & (awaddr_q == TDM_OFF_LIMIT) & wstrb_q[0];
   wire wr_control   = do_write & (awaddr_q == TDM_OFF_CONTROL) & wstrb_q[0];
   wire wr_override  = do_write & (awaddr_q == TDM_OFF_OVERRIDE);
   wire wr_mapped    = (awaddr_q == TDM_OFF_CURRENT) | (awaddr_q == TDM_OFF_AVERAGE) |
                       (awaddr_q == TDM_OFF_INTERVAL) | (awaddr_q == TDM_OFF_FLAGS) |
                       (awaddr_q == TDM_OFF_LIMIT) | (awaddr_q == TDM_OFF_CONTROL) |
                       (awaddr_q == TDM_OFF_OVERRIDE);

   // Period timing: 256 slots, each interval_q cycles long
   wire        sub_end    = (sub_q >= interval_q - 16'h0001) | (interval_q == 16'h0000);
   wire        period_end = sub_end & (slot_q == 8'hFF) & ~asleep;
   // Slot counts as hit if any assertion inside it, giving half-LSB bias
   wire        slot_hit   = hit_slot_q | throttle_asserted;
   wire [8:0]  hit_total  = hit_q + {8'h00, sub_end & slot_hit};
   // Clamp 256 to 255: top code means above 99.2 percent
   wire [7:0]  result     = hit_total[8] ? 8'hFF : hit_total[7:0];
   wire        full_seen  = ~released_q & throttle_asserted;
   wire [8:0]  avg_sum    = {1'b0, average_q} + {1'b0, current_q};

   // Slot divider and slot counter
   always_ff @(posedge aclk) begin
      if (!aresetn || asleep || wr_current) begin
         sub_q  <= 16'h0000;
         slot_q <= 8'h00;
      end else if (sub_end) begin
         sub_q  <= 16'h0000;
         slot_q <= slot_q + 8'h01;
      end else begin
         sub_q  <= sub_q + 16'h0001;
      end
   end

   // Assertion accumulators
   always_ff @(posedge aclk) begin
      if (!aresetn || asleep || wr_current || period_end) begin
         hit_q      <= 9'h000;
         hit_slot_q <= 1'b0;
         released_q <= 1'b0;
      end else begin
         released_q <= released_q | ~throttle_asserted;
         if (sub_end) begin
            hit_q      <= hit_total;
            hit_slot_q <= 1'b0;
         end else begin
            hit_slot_q <= slot_hit;
         end
      end
   end

   // Current and average measurement registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         current_q <= 8'h00;
         average_q <= 8'h00;
         first_q   <= 1'b1;
      end else if (asleep) begin
         current_q <= 8'h00;
         first_q   <= 1'b1;
      end else if (period_end) begin
         current_q <= result;
         first_q   <= 1'b0;
         if (first_q) begin
            average_q <= result;
         end else begin
            average_q <= avg_sum[8:1];
         end
      end
   end

   // Band and limit flags, renewed each period
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_q <= 8'h00;
      end else if (period_end) begin
         flags_q[TDM_FLG_FULL] <= full_seen;
         flags_q[TDM_FLG_B75]  <= (result >= TDM_BAND_75) & ~full_seen;
         flags_q[TDM_FLG_B50]  <= (result >= TDM_BAND_50) & (result < TDM_BAND_75);
         flags_q[TDM_FLG_B25]  <= (result >= TDM_BAND_25) & (result < TDM_BAND_50);
         flags_q[TDM_FLG_B12]  <= (result >= TDM_BAND_12) & (result < TDM_BAND_25);
         flags_q[TDM_FLG_B0]   <= (result != 8'h00) & (result < TDM_BAND_12);
         flags_q[TDM_FLG_ANY]  <= (result != 8'h00);
         flags_q[TDM_FLG_USER] <= (result > limit_q);
      end
   end

   // Only the user-limit flag reaches alert
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alert_out <= 1'b0;
      end else begin
         alert_out <= flags_q[TDM_FLG_USER];
      end
   end

   // Override PWM: period minus one in high byte, low time in low byte
   logic [7:0] pwm_q;
   always_ff @(posedge aclk) begin
      if (!aresetn || pwm_q >= override_q[15:8]) begin
         pwm_q <= 8'h00;
      end else begin
         pwm_q <= pwm_q + 8'h01;
      end
   end

   wire hot_any   = |hot_s2_q;
   wire hot_drive = hot_any & ~asleep & ~control_q[TDM_CTL_HOT_DIS];
   wire ovr_drive = control_q[TDM_CTL_OVR_EN] & (pwm_q < override_q[7:0]);

   // Throttle line driver, low when driven
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         processor_throttle_line_oe <= 1'b0;
         processor_throttle_line_o  <= 1'b0;
      end else begin
         processor_throttle_line_oe <= hot_drive | ovr_drive;
         processor_throttle_line_o  <= 1'b0;
      end
   end

   // Software-written registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         interval_q <= TDM_INTERVAL_RST;
         limit_q    <= TDM_LIMIT_RST;
         control_q  <= 2'b00;
         override_q <= 16'h0000;
      end else begin
         if (wr_interval) interval_q <= wdata_q[15:0];
         if (wr_limit)    limit_q    <= wdata_q[7:0];
         if (wr_control)  control_q  <= wdata_q[1:0];
         if (wr_override) override_q <= wdata_q[15:0];
      end
   end

   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q      <= 1'b0;
         w_got_q       <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= TDM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? TDM_RESP_OKAY : TDM_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Ready flops: one-cycle pulses while a slot is free
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_got_q & ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid;
         s_axi_wready  <= ~w_got_q & ~s_axi_wready & ~s_axi_bvalid & s_axi_wvalid;
      end
   end

   // Read decode
   wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb begin
      rd_ok  = 1'b1;
      unique case (rd_addr)
         TDM_OFF_CURRENT:  rd_mux = {24'h000000, current_q};
         TDM_OFF_AVERAGE:  rd_mux = {24'h000000, average_q};
         TDM_OFF_INTERVAL: rd_mux = {16'h0000, interval_q};
         TDM_OFF_FLAGS:    rd_mux = {24'h000000, flags_q};
         TDM_OFF_LIMIT:    rd_mux = {24'h000000, limit_q};
         TDM_OFF_CONTROL:  rd_mux = {30'h0, control_q};
         TDM_OFF_OVERRIDE: rd_mux = {16'h0000, override_q};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_ok  = 1'b0;
         end
      endcase
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= TDM_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? TDM_RESP_OKAY : TDM_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks
   chk_sleep_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      asleep |=> (current_q == 8'h00))
      else $error("current not cleared in sleep");
   chk_sleep_avg_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      asleep |=> $stable(average_q))
      else $error("average changed in sleep");
   chk_hot_response: assert property (@(posedge aclk) disable iff (!aresetn)
      (hot_any & ~asleep & ~control_q[TDM_CTL_HOT_DIS]) [*2] |-> processor_throttle_line_oe)
      else $error("hot input not driving line");
   chk_hot_sleep_off: assert property (@(posedge aclk) disable iff (!aresetn)
      (asleep & ~ovr_drive) |=> ~processor_throttle_line_oe)
      else $error("line driven in sleep");
   chk_avg_update: assert property (@(posedge aclk) disable iff (!aresetn)
      (period_end & ~first_q) |=> (average_q == $past(avg_sum[8:1])))
      else $error("average wrong");
   chk_first_direct: assert property (@(posedge aclk) disable iff (!aresetn)
      (period_end & first_q) |=> (average_q == current_q))
      else $error("first result not loaded to both");
   chk_zero_bias: assert property (@(posedge aclk) disable iff (!aresetn)
      period_end |=> ((current_q == 8'h00) == ~flags_q[TDM_FLG_ANY]))
      else $error("zero code mismatch");
   chk_user_limit: assert property (@(posedge aclk) disable iff (!aresetn)
      period_end |=> (flags_q[TDM_FLG_USER] == (current_q > limit_q)))
      else $error("user flag wrong");
   chk_restart_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_current |=> (slot_q == 8'h00 && hit_q == 9'h000))
      else $error("capture not restarted");

endmodule

/* tdm_far_side.sv */
// Processor throttle pin and regulator hot outputs
module tdm_far_side (
   // Clock
   input  wire logic       aclk,
   // Pattern and hot request from the bench
   input  wire logic [7:0] low_cyc,
   input  wire logic [7:0] per_cyc,
   input  wire logic [1:0] hot_req,
   // Device side of the open-drain line
   input  wire logic       line_oe,
   input  wire logic       line_o,
   // Resolved line level and regulator outputs
   output logic            line_lvl,
   output logic [1:0]      reg_hot
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_q = 8'h00; // Place in the pattern
   logic       drv_q = 1'b0;  // Processor pulls line low
   // Pattern counter; zero period means 256, early wrap after a shorter period is set
   always @(posedge aclk) begin
      cnt_q   <= (per_cyc != 8'h00 && cnt_q + 8'h01 >= per_cyc) ? 8'h00 : cnt_q + 8'h01;
      drv_q   <= (cnt_q < low_cyc);
      reg_hot <= hot_req;
   end
   // Pull-up wins unless either party pulls low
   assign line_lvl = ~(drv_q | (line_oe & ~line_o));
endmodule

/* tb_throttle_duty_monitor.sv */
module tb_throttle_duty_monitor;
   import tdm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // Bus and pin stimulus
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, low_cyc = 8'h00, per_cyc = 8'h01;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, oe, o, alert_out, line;
   logic [1:0]  bresp, rresp, hot, r, hot_req = 2'h0, sleep_state = TDM_S0;
   int          fail_count = 0, checks = 0, cur_e, avg_e, n, i;
   // Pattern table: low cycles, period, expected result
   logic [7:0]  pl [8] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h07, 8'h01};
   logic [7:0]  pp [8] = '{8'h01, 8'h00, 8'h08, 8'h04, 8'h02, 8'h04, 8'h08, 8'h01};
   int          pv [8] = '{0, 1, 32, 64, 128, 192, 224, 255};
   logic [31:0] rv [8] = '{0, 0, TDM_INTERVAL_RST, 0, TDM_LIMIT_RST, 0, 0, 0};

   always #2 aclk = ~aclk;

   tdm_throttle_duty_monitor #(.HOT_INPUTS(2)) u_tdm_throttle_duty_monitor (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .processor_throttle_line_i(line), .processor_throttle_line_oe(oe),
      .processor_throttle_line_o(o), .regulator_hot_input(hot),
      .sleep_state(sleep_state), .alert_out(alert_out));

   tdm_far_side u_tdm_far_side (
      .aclk(aclk), .low_cyc(low_cyc), .per_cyc(per_cyc), .hot_req(hot_req),
      .line_oe(oe), .line_o(o), .line_lvl(line), .reg_hot(hot));

   // Verdict and end of run
   task automatic complete_run();
      if (fail_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Expired wait
   task automatic tmo();
      chk("handshake", 0, 1);
      complete_run();
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge aclk);
   endtask

   // Write: address and data together, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int k;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 64; k++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (k == 64) tmo();
   endtask

   // Read one word
   task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int k;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 64; k++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (k == 64) tmo();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] rs;
      axw(a, v, rs);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0]  rs;
      axr(a, v, rs);
      chk(nm, v, e);
   endtask

   // Flags expected from a result and the user limit
   function automatic logic [7:0] eflg(input int v, input int lim);
      eflg = 8'h00;
      eflg[TDM_FLG_FULL] = (v == 255);
      eflg[TDM_FLG_B75]  = (v >= 193 && v < 255);
      eflg[TDM_FLG_B50]  = (v >= 129 && v < 193);
      eflg[TDM_FLG_B25]  = (v >= 65 && v < 129);
      eflg[TDM_FLG_B12]  = (v >= 33 && v < 65);
      eflg[TDM_FLG_B0]   = (v >= 1 && v < 33);
      eflg[TDM_FLG_ANY]  = (v > 0);
      eflg[TDM_FLG_USER] = (v > lim);
   endfunction

   // Main sequence
   initial begin
      cyc(8);
      aresetn <= 1'b1;
      // Reset values, unmapped word last
      for (i = 0; i < 8; i++) begin
         axr(8'(i * 4), d, r);
         chk("reset value", d, rv[i]);
         chk("read resp", r, (i == 7) ? TDM_RESP_SLVERR : TDM_RESP_OKAY);
      end
      axw(8'h1C, 32'h5A, r);
      chk("write resp", r, TDM_RESP_SLVERR);
      wr(TDM_OFF_INTERVAL, 32'h1);
      rchk("interval", TDM_OFF_INTERVAL, 32'h1);
      wr(TDM_OFF_LIMIT, 32'd100);
      cur_e = 0;
      avg_e = 0;
      // Every band through duty patterns, restart, then two periods
      for (i = 0; i < 8; i++) begin
         low_cyc <= pl[i];
         per_cyc <= pp[i];
         cyc(8);
         wr(TDM_OFF_CURRENT, 32'h0);
         cyc(300);
         avg_e = (avg_e + cur_e) / 2;
         cur_e = pv[i];
         rchk("current", TDM_OFF_CURRENT, cur_e);
         rchk("flags", TDM_OFF_FLAGS, eflg(cur_e, 100));
         chk("alert", alert_out, cur_e > 100);
         rchk("average", TDM_OFF_AVERAGE, avg_e);
         cyc(240);
         avg_e = (avg_e + cur_e) / 2;
         rchk("average", TDM_OFF_AVERAGE, avg_e);
      end
      // Sleep clears current, keeps average, blocks hot drive
      sleep_state <= TDM_S3;
      hot_req <= 2'b01;
      low_cyc <= 8'h01;
      per_cyc <= 8'h04;
      cyc(20);
      chk("drive in sleep", oe, 1'b0);
      // Drop the hot request well before waking so no stray drive lands in the first period
      hot_req <= 2'b00;
      rchk("current", TDM_OFF_CURRENT, 0);
      rchk("average", TDM_OFF_AVERAGE, avg_e);
      sleep_state <= TDM_S0;
      cyc(300);
      rchk("current", TDM_OFF_CURRENT, 64);
      rchk("average", TDM_OFF_AVERAGE, 64);
      wr(TDM_OFF_AVERAGE, 32'hAA);
      rchk("average", TDM_OFF_AVERAGE, 64);
      // Hot drive held off in the deeper sleep code
      sleep_state <= TDM_S45;
      hot_req <= 2'b10;
      low_cyc <= 8'h00;
      cyc(20);
      chk("drive in sleep", oe, 1'b0);
      sleep_state <= TDM_S0;
      for (n = 0; n < TDM_HOT_RESP_CY && oe !== 1'b1; n++) @(posedge aclk);
      chk("hot drive", oe, 1'b1);
      chk("drive level", o, 1'b0);
      chk("line level", line, 1'b0);
      hot_req <= 2'b00;
      for (n = 0; n < TDM_HOT_RESP_CY && oe !== 1'b0; n++) @(posedge aclk);
      chk("hot release", oe, 1'b0);
      wr(TDM_OFF_CONTROL, 32'h1 << TDM_CTL_HOT_DIS);
      hot_req <= 2'b01;
      cyc(20);
      chk("hot disabled", oe, 1'b0);
      // Override: period 4, low one cycle in four
      hot_req <= 2'b00;
      wr(TDM_OFF_OVERRIDE, 32'h0301);
      wr(TDM_OFF_CONTROL, 32'h1 << TDM_CTL_OVR_EN);
      cyc(20);
      n = 0;
      repeat (400) begin
         @(posedge aclk);
         n += (oe === 1'b1);
      end
      chk("override low cycles", n, 100);
      complete_run();
   end
endmodule
